/* adc_readout_consts.vh */
// constants for the conversion sequencer and serial readout
`ifndef ADC_READOUT_CONSTS_VH
`define ADC_READOUT_CONSTS_VH

// ==========================================
// conversion timing: crystal rate in Hz, counts in crystal periods (settle count in result periods), counter widths
`define XTAL_HZ          32768
`define RATE_DIV_A       69
`define RATE_DIV_B       8
`define RATE_DIV_C       3
`define RESULT_PERIOD    (`RATE_DIV_A * `RATE_DIV_B * `RATE_DIV_C)
`define SETTLE_PERIODS   2
`define LOCK_PERIODS     64
`define PERIOD_CNT_W     11
`define LOCK_CNT_W       8
`define SETTLE_W         2

// ==========================================
// result word
`define WORD_BITS        24
`define WORD_MSB         23
`define BIT_CNT_W        5
`define FIFO_DEPTH       8
`define FIFO_AW          3

// ==========================================
// mode pin coding
`define MODE_MASTER      1'h0
`define MODE_SLAVE       1'h1

`endif

/* sync_two_ff.v */
// two flip-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ns
module sync_two_ff #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
    input  wire             clk_sys,
    input  wire             rst,
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);

// ==========================================
// first stage is read only by the second
reg [WIDTH-1:0] meta;

always @(posedge clk_sys) begin
    if (rst) begin
        meta     <= INIT;
        sync_out <= INIT;
    end else begin
        meta     <= async_in;
        sync_out <= meta;
    end
end

endmodule

/* result_fifo.v */
// result word fifo between filter and output shift register
`timescale 1ns/1ns
module result_fifo #(
    parameter WIDTH = 24,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             clk_sys,
    input  wire             rst,
    input  wire             flush,
    input  wire             in_valid,
    output reg              in_ready,
    input  wire [WIDTH-1:0] in_data,
    output reg              out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);

// ==========================================
// storage and pointers
reg [WIDTH-1:0] mem [0:DEPTH-1];
reg [AW-1:0]    wr_ptr;
reg [AW-1:0]    rd_ptr;
reg [AW:0]      count;
reg [AW:0]      next_count;

wire push = in_valid & in_ready;
wire pop  = out_valid & out_ready;

assign out_data = mem[rd_ptr];

always @* begin
    next_count = count;
    if (push & ~pop) begin
        next_count = count + 1'b1;
    end else if (pop & ~push) begin
        next_count = count - 1'b1;
    end
end

// ==========================================
// ready and valid are registered so the pins come from flops
always @(posedge clk_sys) begin
    if (rst | flush) begin
        wr_ptr    <= {AW{1'b0}};
        rd_ptr    <= {AW{1'b0}};
        count     <= {(AW+1){1'b0}};
        in_ready  <= 1'b1;
        out_valid <= 1'b0;
    end else begin
        if (push) begin
            wr_ptr <= (wr_ptr == DEPTH - 1) ? {AW{1'b0}} : wr_ptr + 1'b1;
        end
        if (pop) begin
            rd_ptr <= (rd_ptr == DEPTH - 1) ? {AW{1'b0}} : rd_ptr + 1'b1;
        end
        count     <= next_count;
        in_ready  <= (next_count != DEPTH);
        out_valid <= (next_count != {(AW+1){1'b0}});
    end
end

always @(posedge clk_sys) begin
    if (push) begin
        mem[wr_ptr] <= in_data;
    end
end

endmodule

/* adc_conversion_serial_readout.v */
// conversion sequencing and read-only serial output of a two-pair converter
// ==========================================
// Overview of operation
// - select low powers up, locks, then converts
// - select high aborts, floats pins, drops result
// - conversions repeat while select stays low
// - ready high during conversion, low when done
// - unread result: ready high before next update
// - full read completes: ready returns high
// - slave mode: falling ready is interrupt
// - master: ready low half period before clocks
// - bits change on fall, sampled on rise
// - mode 0 master, mode 1 slave
// - master drives serial clock, slave receives it
// - result period is 1656 crystal periods
// - settle two periods after start or switch
// - master emits 24 clocks, then idles high
// - result word is offset binary
// - master serial clock period equals crystal period
`timescale 1ns/1ns
`include "adc_readout_consts.vh"
module adc_conversion_serial_readout #(
    parameter LOCK_PERIODS   = `LOCK_PERIODS,
    parameter RESULT_PERIOD  = `RESULT_PERIOD,
    parameter SETTLE_PERIODS = `SETTLE_PERIODS,
    parameter FIFO_DEPTH     = `FIFO_DEPTH,
    parameter FIFO_AW        = `FIFO_AW
) (
    input  wire                    clk_sys,
    input  wire                    rst,
    input  wire                    cs_n,
    input  wire                    mode,
    input  wire                    input_pair_select,
    input  wire                    crystal_in,
    output reg                     crystal_out,
    input  wire                    sclk_in,
    output reg                     sclk_out,
    output reg                     sclk_oe,
    output reg                     dout_rdy_n,
    output reg                     dout_oe,
    input  wire                    sample_valid,
    output wire                    sample_ready,
    input  wire [`WORD_MSB:0]      sample_twos,
    output reg                     conv_active,
    output reg                     active_pair
);

// ==========================================
// states
localparam [4:0] ST_OFF   = 5'h01;
localparam [4:0] ST_LOCK  = 5'h02;
localparam [4:0] ST_CONV  = 5'h04;
localparam [4:0] ST_READY = 5'h08;
localparam [4:0] ST_SHIFT = 5'h10;

// counts are cut to their counter widths on purpose
localparam integer PERIOD_LAST_I = RESULT_PERIOD - 1;
localparam integer PERIOD_WARN_I = RESULT_PERIOD - 2;
localparam integer LOCK_LAST_I   = LOCK_PERIODS - 1;
localparam integer SETTLE_INIT_I = SETTLE_PERIODS - 1;
localparam integer BIT_LAST_I    = `WORD_BITS - 1;

localparam [`PERIOD_CNT_W-1:0] PERIOD_LAST = PERIOD_LAST_I[`PERIOD_CNT_W-1:0];
localparam [`PERIOD_CNT_W-1:0] PERIOD_WARN = PERIOD_WARN_I[`PERIOD_CNT_W-1:0];
localparam [`LOCK_CNT_W-1:0]   LOCK_LAST   = LOCK_LAST_I[`LOCK_CNT_W-1:0];
localparam [`SETTLE_W-1:0]     SETTLE_INIT = SETTLE_INIT_I[`SETTLE_W-1:0];
localparam [`BIT_CNT_W-1:0]    BIT_LAST    = BIT_LAST_I[`BIT_CNT_W-1:0];

// ==========================================
// pin synchronisers
wire [4:0] pins_s;

sync_two_ff #(
    .WIDTH (5),
    .INIT  (5'h19)
) u_sync (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .async_in ({cs_n, mode, input_pair_select, crystal_in, sclk_in}),
    .sync_out (pins_s)
);

wire cs_high  = pins_s[4];
wire mode_s   = pins_s[3];
wire pair_s   = pins_s[2];
wire xtal_s   = pins_s[1];
wire sclk_s   = pins_s[0];

// edge detectors look only at the second stage
reg xtal_q;
reg sclk_q;
reg pair_q;

always @(posedge clk_sys) begin
    if (rst) begin
        xtal_q <= 1'b0;
        sclk_q <= 1'b1;
        pair_q <= 1'b0;
    end else begin
        xtal_q <= xtal_s;
        sclk_q <= sclk_s;
        pair_q <= pair_s;
    end
end

wire x_rise = xtal_s & ~xtal_q;
wire x_fall = ~xtal_s & xtal_q;
wire s_rise = sclk_s & ~sclk_q;
wire s_fall = ~sclk_s & sclk_q;
wire is_master = (mode_s == `MODE_MASTER);

// master clocks from crystal edges so one serial period is one crystal period
wire fall_ev = is_master ? x_fall : s_fall;
wire rise_ev = is_master ? x_rise : s_rise;

// ==========================================
// result fifo
reg                 flush;
reg  [`WORD_MSB:0]  shreg;
wire                fifo_valid;
wire [`WORD_MSB:0]  fifo_data;
wire [`WORD_MSB:0]  sample_ofs = {~sample_twos[`WORD_MSB], sample_twos[`WORD_MSB-1:0]};

reg  [4:0]                 state;
reg  [`PERIOD_CNT_W-1:0]   period_cnt;
reg  [`LOCK_CNT_W-1:0]     lock_cnt;
reg  [`SETTLE_W-1:0]       settle;
reg  [`BIT_CNT_W-1:0]      bit_cnt;
reg                        word_end;

wire running   = (state == ST_CONV) | (state == ST_READY) | (state == ST_SHIFT);
wire update_ev = running & x_rise & (period_cnt == PERIOD_LAST);
wire pop       = update_ev & fifo_valid;

result_fifo #(
    .WIDTH (`WORD_BITS),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
) u_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .flush     (flush),
    .in_valid  (sample_valid),
    .in_ready  (sample_ready),
    .in_data   (sample_ofs),
    .out_valid (fifo_valid),
    .out_ready (pop),
    .out_data  (fifo_data)
);

// ==========================================
// sequencer and shifter
always @(posedge clk_sys) begin
    if (rst) begin
        state       <= ST_OFF;
        period_cnt  <= {`PERIOD_CNT_W{1'b0}};
        lock_cnt    <= {`LOCK_CNT_W{1'b0}};
        settle      <= {`SETTLE_W{1'b0}};
        bit_cnt     <= {`BIT_CNT_W{1'b0}};
        shreg       <= {`WORD_BITS{1'b0}};
        sclk_out    <= 1'b1;
        sclk_oe     <= 1'b0;
        dout_rdy_n  <= 1'b1;
        dout_oe     <= 1'b0;
        flush       <= 1'b1;
        conv_active <= 1'b0;
        active_pair <= 1'b0;
        crystal_out <= 1'b1;
        word_end    <= 1'b0;
    end else begin
        crystal_out <= ~xtal_s;
        active_pair <= pair_s;
        flush       <= 1'b0;
        if (cs_high) begin
            // abort, float, standby, lose the held word
            state       <= ST_OFF;
            dout_oe     <= 1'b0;
            sclk_oe     <= 1'b0;
            dout_rdy_n  <= 1'b1;
            sclk_out    <= 1'b1;
            conv_active <= 1'b0;
            flush       <= 1'b1;
            shreg       <= {`WORD_BITS{1'b0}};
            word_end    <= 1'b0;
        end else begin
            conv_active <= 1'b1;
            dout_oe     <= 1'b1;
            sclk_oe     <= is_master;
            word_end    <= 1'b0;
            if (word_end) begin
                dout_rdy_n <= 1'b1;
            end
            case (state)
                ST_OFF: begin
                    state      <= ST_LOCK;
                    lock_cnt   <= {`LOCK_CNT_W{1'b0}};
                    dout_rdy_n <= 1'b1;
                    sclk_out   <= 1'b1;
                end
                ST_LOCK: begin
                    if (x_rise) begin
                        if (lock_cnt == LOCK_LAST) begin
                            state      <= ST_CONV;
                            period_cnt <= {`PERIOD_CNT_W{1'b0}};
                            settle     <= SETTLE_INIT;
                            flush      <= 1'b1;
                        end else begin
                            lock_cnt <= lock_cnt + 1'b1;
                        end
                    end
                end
                ST_CONV, ST_READY, ST_SHIFT: begin
                    if (pair_s != pair_q) begin
                        // pair switched: restart the period and settle again
                        state      <= ST_CONV;
                        period_cnt <= {`PERIOD_CNT_W{1'b0}};
                        settle     <= SETTLE_INIT;
                        dout_rdy_n <= 1'b1;
                        sclk_out   <= 1'b1;
                        flush      <= 1'b1;
                    end else if (update_ev) begin
                        period_cnt <= {`PERIOD_CNT_W{1'b0}};
                        if (settle != {`SETTLE_W{1'b0}}) begin
                            settle <= settle - 1'b1;
                        end else if (fifo_valid) begin
                            shreg      <= fifo_data;
                            state      <= ST_READY;
                            dout_rdy_n <= 1'b0;
                            bit_cnt    <= {`BIT_CNT_W{1'b0}};
                        end
                    end else begin
                        if (x_rise) begin
                            period_cnt <= period_cnt + 1'b1;
                        end
                        if (x_rise & (period_cnt == PERIOD_WARN)) begin
                            // unread word: warn before the register changes
                            state      <= ST_CONV;
                            dout_rdy_n <= 1'b1;
                            sclk_out   <= 1'b1;
                        end else if ((state == ST_READY) | (state == ST_SHIFT)) begin
                            // master: first fall comes half a crystal period after ready; in slave mode the host sets it
                            if (fall_ev) begin
                                dout_rdy_n <= shreg[`WORD_MSB];
                                shreg      <= {shreg[`WORD_MSB-1:0], 1'b0};
                                sclk_out   <= 1'b0;
                                state      <= ST_SHIFT;
                            end else if (rise_ev & (state == ST_SHIFT)) begin
                                sclk_out <= 1'b1;
                                if (bit_cnt == BIT_LAST) begin
                                    // last bit holds one cycle past the final rise for host hold
                                    state      <= ST_CONV;
                                    word_end   <= 1'b1;
                                end else begin
                                    bit_cnt <= bit_cnt + 1'b1;
                                end
                            end
                        end
                    end
                end
                default: begin
                    // an illegal code sends the sequencer to standby, from which it locks again at once
                    state <= ST_OFF;
                end
            endcase
        end
    end
end

endmodule

/* adc_readout_checker.sv */
// assertion checker for the conversion readout block
`timescale 1ns/1ns
module adc_readout_checker (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic mode,
    input wire logic sclk_out,
    input wire logic sclk_oe,
    input wire logic dout_rdy_n,
    input wire logic dout_oe,
    input wire logic conv_active
);
    // ==========================================
    // helpers
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic [5:0] falls;
    logic       sclk_q;
    logic       rdy_q;
    // restart at each publication, which falls while the clock is high
    always @(posedge clk_sys) begin
        sclk_q <= sclk_out;
        rdy_q  <= dout_rdy_n;
        if (rst || (rdy_q && !dout_rdy_n && sclk_out))
            falls <= 6'h00;
        else if (sclk_q && !sclk_out)
            falls <= falls + 6'h01;
    end
    sequence s_publish;
        sclk_oe && sclk_out && $fell(dout_rdy_n);
    endsequence
    sequence s_word_end;
        sclk_oe && dout_oe && sclk_out && $rose(dout_rdy_n);
    endsequence
    // ==========================================
    // properties
    a_float_deselect: assert property ($rose(cs_n) |-> ##[1:4] (!dout_oe && !sclk_oe))
        else $error("pins driven after deselect");
    a_float_held: assert property (cs_n [*4] |-> !dout_oe && !sclk_oe)
        else $error("pins driven while deselected");
    a_powered_up: assert property (!cs_n [*4] |-> conv_active && dout_oe)
        else $error("not active while selected");
    a_master_clock: assert property ((!cs_n && !mode) [*4] |-> sclk_oe)
        else $error("master does not drive clock");
    a_slave_clock: assert property (mode [*4] |-> !sclk_oe)
        else $error("slave drives clock");
    a_ready_lead: assert property (s_publish |-> sclk_out [*3])
        else $error("clock starts too soon after ready");
    a_half_period: assert property (disable iff (rst || cs_n)
        sclk_oe && $fell(sclk_out) |-> !sclk_out [*3] ##[1:3] sclk_out) else $error("bad clock low phase");
    a_stable_low: assert property (disable iff (rst || cs_n)
        sclk_oe && dout_oe && !sclk_out && !$past(sclk_out) && !$past(sclk_out, 2) |-> $stable(dout_rdy_n))
        else $error("data moved during low phase");
    a_no_extra: assert property (sclk_oe && $fell(sclk_out) |-> falls < 6'h18)
        else $error("more than 24 clocks");
    a_word_clocks: assert property (disable iff (rst || cs_n)
        s_publish |-> ##[185:230] falls == 6'h18) else $error("24 clocks not sent");
    a_idle_high: assert property (s_word_end |-> sclk_out [*8])
        else $error("clock not idle after word");
endmodule
bind adc_conversion_serial_readout adc_readout_checker chk (
    .clk_sys(clk_sys), .rst(rst), .cs_n(cs_n), .mode(mode), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
    .dout_rdy_n(dout_rdy_n), .dout_oe(dout_oe), .conv_active(conv_active)
);

/* host_serial_model.sv */
// host serial port model: clocks slave reads, samples every word
`timescale 1ns/1ns
module host_serial_model (
    input  wire logic        clk_sys,
    input  wire logic        start,
    input  wire logic        sclk_line,
    input  wire logic        dout_line,
    output logic             sclk_drv,
    output logic [23:0]      word
);
    integer i;
    initial begin
        sclk_drv = 1'b1;
        word     = 24'h00_0000;
    end
    always @(posedge sclk_line) begin
        word <= {word[22:0], dout_line};
    end
    // byte batches with idle high gaps, as a small controller would
    always @(posedge start) begin
        for (i = 0; i < 24; i = i + 1) begin
            repeat (4) @(posedge clk_sys);
            #5 sclk_drv = 1'b0;
            repeat (4) @(posedge clk_sys);
            #5 sclk_drv = 1'b1;
            if (i % 8 == 7)
                repeat (10) @(posedge clk_sys);
        end
    end
endmodule

/* tb_top.sv */
// self-checking bench for the conversion readout block
`timescale 1ns/1ns
module tb_top;
    logic        clk_sys = 1'b0;
    logic        rst     = 1'b1;
    logic        cs_n    = 1'b1;
    logic        mode    = 1'b0;
    logic        pair    = 1'b0;
    logic        xtal    = 1'b0;
    logic        s_valid = 1'b0;
    logic [23:0] s_twos  = 24'h00_0000;
    logic        start   = 1'b0;
    wire         sclk_out, sclk_oe, rdy_n, dout_oe, s_ready, conv_active, active_pair, sclk_drv, crystal_out;
    wire  [23:0] word;
    // a released data pin shows the inverse of rdy_n, which is then held high, so it reads low; a released clock carries the host drive
    wire         sclk_line = sclk_oe ? sclk_out : sclk_drv;
    wire         dout_line = dout_oe ? rdy_n : ~rdy_n;
    integer      num_errors = 0;
    integer      n_tests    = 0;
    integer      n;
    integer      k;
    // mode, pair, filter word, published word
    logic [49:0] rows [6] = '{
        {1'b0, 1'b0, 24'h00_0000, 24'h80_0000}, {1'b1, 1'b1, 24'h80_0000, 24'h00_0000},
        {1'b0, 1'b1, 24'h7f_ffff, 24'hff_ffff}, {1'b1, 1'b0, 24'h12_3456, 24'h92_3456},
        {1'b0, 1'b0, 24'hfe_dcba, 24'h7e_dcba}, {1'b1, 1'b1, 24'h00_0001, 24'h80_0001}};
    initial forever #50 clk_sys = ~clk_sys;
    initial begin
        #137;
        forever #400 xtal = ~xtal;
    end
    // short lock and period keep the run brief
    adc_conversion_serial_readout #(.LOCK_PERIODS(2), .RESULT_PERIOD(40)) dut (
        .clk_sys(clk_sys), .rst(rst), .cs_n(cs_n), .mode(mode), .input_pair_select(pair),
        .crystal_in(xtal), .crystal_out(crystal_out),
        .sclk_in(sclk_line), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
        .dout_rdy_n(rdy_n), .dout_oe(dout_oe), .sample_valid(s_valid), .sample_ready(s_ready),
        .sample_twos(s_twos), .conv_active(conv_active), .active_pair(active_pair));
    host_serial_model host (.clk_sys(clk_sys), .start(start), .sclk_line(sclk_line),
        .dout_line(dout_line), .sclk_drv(sclk_drv), .word(word));
    // ==========================================
    // tasks
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input integer c);
        repeat (c) @(posedge clk_sys);
        #5;
    endtask
    task automatic wait_rdy(input logic lvl, input integer lim);
        n = 0;
        while (rdy_n !== lvl && n < lim) begin
            tick(1);
            n = n + 1;
        end
        check("ready level", 24'(rdy_n), 24'(lvl));
    endtask
    task automatic results;
        if (num_errors == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ==========================================
    // sequence
    initial begin
        tick(12);
        check("idle pins", 24'({dout_oe, sclk_oe, conv_active, rdy_n, sclk_out}), 24'h00_0003);
        rst = 1'b0;
        for (k = 0; k < 6; k = k + 1) begin
            {mode, pair, s_twos} = rows[k][49:24];
            s_valid = 1'b1;
            cs_n = 1'b0;
            wait_rdy(1'b0, 900);
            check("first word time", 24'(n >= 640 && n <= 700), 24'h00_0001);
            check("crystal out", 24'(crystal_out), 24'(!xtal));
            check("pair", 24'(active_pair), 24'(pair));
            check("clock dir", 24'(sclk_oe), 24'(!mode));
            if (mode) begin
                start = 1'b1;
                tick(1);
                start = 1'b0;
            end
            tick(260);
            check("word", word, rows[k][23:0]);
            check("ready after read", 24'(rdy_n), 24'h00_0001);
            check("fifo full", 24'(s_ready), 24'h00_0000);
            cs_n = 1'b1;
            tick(6);
            check("float", 24'({dout_oe, sclk_oe, conv_active}), 24'h00_0000);
        end
        // unread word: ready rises one crystal period ahead of the next update
        cs_n = 1'b0;
        wait_rdy(1'b0, 900);
        wait_rdy(1'b1, 400);
        check("early rise", 24'(n >= 300 && n <= 320), 24'h00_0001);
        wait_rdy(1'b0, 40);
        check("next word", 24'(n >= 6 && n <= 12), 24'h00_0001);
        // pair switch while running: ready high at once, word after two periods
        pair = ~pair;
        wait_rdy(1'b1, 10);
        wait_rdy(1'b0, 900);
        check("settle after switch", 24'(n >= 620 && n <= 660), 24'h00_0001);
        check("pair", 24'(active_pair), 24'(pair));
        // deselect in mid read of a master transfer
        cs_n = 1'b1;
        tick(6);
        mode = 1'b0;
        cs_n = 1'b0;
        wait_rdy(1'b0, 900);
        tick(50);
        cs_n = 1'b1;
        tick(4);
        check("abort", 24'({dout_oe, sclk_oe}), 24'h00_0000);
        cs_n = 1'b0;
        tick(40);
        wait_rdy(1'b0, 900);
        check("result lost", 24'(n >= 590), 24'h00_0001);
        // reset in mid run: pins idle for two edges after release, then a full restart
        rst = 1'b1;
        tick(3);
        rst = 1'b0;
        tick(2);
        check("reset pins", 24'({dout_oe, sclk_oe, conv_active, rdy_n, sclk_out}), 24'h00_0003);
        wait_rdy(1'b0, 900);
        check("restart", 24'(n >= 640 && n <= 700), 24'h00_0001);
        results;
    end
    initial begin
        #2000000;
        num_errors = num_errors + 1;
        results;
    end
endmodule
